// >>> rtl/eprgm_pkg.sv
// Package for the EPROM programmer controller: timing, types and states
//
// Summary of operation
// - Program mode needs high supply, select low.
// - Byte presented on eight data pins parallel.
// - Program pulse lasts 95 to 105 us.
// - Address, data valid 2 us before pulse.
// - Supplies raised 2 us before first pulse.
// - Hold data 2 us, then 2 us more.
// - Outputs release in 130 ns; address after.
// - Repeat 100 us pulses until verify matches; code stops after MAX_PULSES pulses and sets fail.
// - Only a selected device gets programmed.
// - Verify: enable low, select high, supplies high.
// - Identifier mode: high voltage on line nine.
// - Other address lines low during identifier read.
// - Normal read needs select and enable low.
`default_nettype none
package eprgm_pkg;
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned ADDR_W = 19;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned T_SETUP_US = 2;
    localparam int unsigned T_PULSE_US = 100;
    localparam int unsigned T_VERIFY_NS = 100;
    localparam int unsigned T_RELEASE_NS = 130;
    localparam int unsigned SETUP_CYC = T_SETUP_US * CLK_MHZ;
    localparam int unsigned PULSE_CYC = T_PULSE_US * CLK_MHZ;
    localparam int unsigned VERIFY_CYC = (T_VERIFY_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned RELEASE_CYC =
        (T_RELEASE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned MAX_PULSES = 25;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned PCNT_W = 8;

    typedef enum logic [3:0] {
        EPRGM_IDLE = 4'h0,
        EPRGM_PWR = 4'h1,
        EPRGM_SETUP = 4'h3,
        EPRGM_PULSE = 4'h2,
        EPRGM_HOLD = 4'h6,
        EPRGM_OES = 4'h7,
        EPRGM_VERIFY = 4'h5,
        EPRGM_RELEASE = 4'h4,
        EPRGM_DONE = 4'hC,
        EPRGM_READ = 4'hD,
        EPRGM_RDREL = 4'hF
    } eprgm_state_t;

    typedef enum logic [1:0] {
        EPRGM_OP_PROG = 2'h0,
        EPRGM_OP_READ = 2'h1,
        EPRGM_OP_SIG = 2'h2
    } eprgm_op_t;

    typedef struct packed {
        eprgm_op_t op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } eprgm_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic fail;
        logic [PCNT_W-1:0] pulses;
    } eprgm_rsp_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dout;
        logic dout_en;
        logic chip_sel_n;
        logic out_en_n;
        logic vpp_hi;
        logic vcc_prog;
        logic sig_hv;
    } eprgm_pins_t;

    typedef struct packed {
        eprgm_state_t st;
        eprgm_req_t req;
        eprgm_rsp_t rsp;
        eprgm_pins_t pins;
        logic [CNT_W-1:0] cnt;
        logic powered;
        logic done;
    } eprgm_regs_t;
endpackage
`default_nettype wire

// >>> rtl/eprgm_ctrl.sv
// Controller that programs, verifies, reads and identifies a byte EPROM
`default_nettype none
module eprgm_ctrl #(
    parameter int unsigned MAX_PULSES = eprgm_pkg::MAX_PULSES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Request side
    input wire logic req_valid,
    output logic req_ready,
    input wire eprgm_pkg::eprgm_req_t req,
    output logic rsp_valid,
    output eprgm_pkg::eprgm_rsp_t rsp,
    // Device pins
    output eprgm_pkg::eprgm_pins_t pins,
    input wire logic [eprgm_pkg::DATA_W-1:0] data_pins_in
);
    import eprgm_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks on parameters and timing counts
    if (MAX_PULSES < 1 || MAX_PULSES >= (1 << PCNT_W)) begin
        $error("MAX_PULSES out of range");
    end

    // Every wait must fit the down counter
    if (PULSE_CYC >= (1 << CNT_W) || SETUP_CYC >= (1 << CNT_W)
        || VERIFY_CYC + 2 >= (1 << CNT_W)
        || RELEASE_CYC >= (1 << CNT_W)) begin
        $error("Timing counts do not fit the counter");
    end

    // Identifier mode needs address line nine and bit zero
    if (ADDR_W < 10) begin
        $error("Address bus too narrow for identifier mode");
    end

    // Bytes go out eight bits in parallel
    if (DATA_W != 8) begin
        $error("Data bus must be eight bits wide");
    end

    ////////////////////////////////////////////////////////////////////////
    // Input synchroniser for the data pins
    logic [DATA_W-1:0] din_s1_q;
    logic [DATA_W-1:0] din_s2_q;

    always_ff @(posedge clock) begin
        if (rst) begin
            din_s1_q <= 8'hFF;
            din_s2_q <= 8'hFF;
        end else begin
            din_s1_q <= data_pins_in;
            din_s2_q <= din_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    eprgm_regs_t r_q;
    eprgm_regs_t r_d;
    localparam logic [CNT_W-1:0] SETUP_N = CNT_W'(SETUP_CYC);
    localparam logic [CNT_W-1:0] PULSE_N = CNT_W'(PULSE_CYC);
    // Sample after access time plus two synchroniser stages
    localparam logic [CNT_W-1:0] VERIFY_N = CNT_W'(VERIFY_CYC + 2);
    localparam logic [CNT_W-1:0] RELEASE_N = CNT_W'(RELEASE_CYC);

    always_comb begin
        r_d = r_q;
        r_d.done = 1'b0;
        if (r_q.cnt != '0) begin
            r_d.cnt = r_q.cnt - 1'b1;
        end
        case (r_q.st)
            EPRGM_IDLE: begin
                if (req_valid) begin
                    r_d.req = req;
                    r_d.rsp = '0;
                    r_d.pins.addr = req.addr;
                    if (req.op == EPRGM_OP_PROG) begin
                        r_d.pins.vpp_hi = 1'b1;
                        r_d.pins.vcc_prog = 1'b1;
                        r_d.pins.sig_hv = 1'b0;
                        r_d.pins.dout = req.data;
                        r_d.pins.dout_en = 1'b1;
                        r_d.cnt = SETUP_N;
                        r_d.st = EPRGM_SETUP;
                        if (!r_q.powered) begin
                            r_d.st = EPRGM_PWR;
                        end
                    end else if (req.op != EPRGM_OP_READ
                        && req.op != EPRGM_OP_SIG) begin
                        // Unknown operation: report failure, touch no pin
                        r_d.pins.addr = r_q.pins.addr;
                        r_d.rsp.fail = 1'b1;
                        r_d.st = EPRGM_DONE;
                    end else begin
                        r_d.pins.vpp_hi = 1'b0;
                        r_d.pins.vcc_prog = 1'b0;
                        r_d.powered = 1'b0;
                        r_d.pins.dout_en = 1'b0;
                        if (req.op == EPRGM_OP_SIG) begin
                            r_d.pins.sig_hv = 1'b1;
                            r_d.pins.addr = '0;
                            r_d.pins.addr[0] = req.addr[0];
                        end else begin
                            r_d.pins.sig_hv = 1'b0;
                        end
                        r_d.cnt = SETUP_N;
                        r_d.st = EPRGM_PWR;
                    end
                end
            end
            EPRGM_PWR: begin
                if (r_q.cnt == '0) begin
                    if (r_q.req.op == EPRGM_OP_PROG) begin
                        r_d.powered = 1'b1;
                        r_d.cnt = SETUP_N;
                        r_d.st = EPRGM_SETUP;
                    end else begin
                        // Select and enable together for a read
                        r_d.pins.chip_sel_n = 1'b0;
                        r_d.pins.out_en_n = 1'b0;
                        r_d.cnt = VERIFY_N;
                        r_d.st = EPRGM_READ;
                    end
                end
            end
            EPRGM_SETUP: begin
                if (r_q.cnt == '0) begin
                    r_d.pins.chip_sel_n = 1'b0;
                    r_d.cnt = PULSE_N;
                    r_d.rsp.pulses = r_q.rsp.pulses + 1'b1;
                    r_d.st = EPRGM_PULSE;
                end
            end
            EPRGM_PULSE: begin
                if (r_q.cnt == '0) begin
                    r_d.pins.chip_sel_n = 1'b1;
                    r_d.cnt = SETUP_N;
                    r_d.st = EPRGM_HOLD;
                end
            end
            EPRGM_HOLD: begin
                if (r_q.cnt == '0) begin
                    r_d.pins.dout_en = 1'b0;
                    r_d.cnt = SETUP_N;
                    r_d.st = EPRGM_OES;
                end
            end
            EPRGM_OES: begin
                if (r_q.cnt == '0) begin
                    r_d.pins.out_en_n = 1'b0;
                    r_d.cnt = VERIFY_N;
                    r_d.st = EPRGM_VERIFY;
                end
            end
            EPRGM_VERIFY: begin
                if (r_q.cnt == '0) begin
                    r_d.rsp.data = din_s2_q;
                    r_d.pins.out_en_n = 1'b1;
                    r_d.cnt = RELEASE_N;
                    r_d.st = EPRGM_RELEASE;
                end
            end
            EPRGM_RELEASE: begin
                if (r_q.cnt == '0) begin
                    if (r_q.rsp.data == r_q.req.data) begin
                        r_d.st = EPRGM_DONE;
                    end else if (r_q.rsp.pulses >= PCNT_W'(MAX_PULSES)) begin
                        r_d.rsp.fail = 1'b1;
                        r_d.st = EPRGM_DONE;
                    end else begin
                        r_d.pins.dout = r_q.req.data;
                        r_d.pins.dout_en = 1'b1;
                        r_d.cnt = SETUP_N;
                        r_d.st = EPRGM_SETUP;
                    end
                end
            end
            EPRGM_READ: begin
                if (r_q.cnt == '0) begin
                    r_d.rsp.data = din_s2_q;
                    r_d.pins.out_en_n = 1'b1;
                    r_d.pins.chip_sel_n = 1'b1;
                    r_d.cnt = RELEASE_N;
                    r_d.st = EPRGM_RDREL;
                end
            end
            EPRGM_RDREL: begin
                if (r_q.cnt == '0) begin
                    r_d.pins.sig_hv = 1'b0;
                    r_d.st = EPRGM_DONE;
                end
            end
            EPRGM_DONE: begin
                r_d.done = 1'b1;
                r_d.st = EPRGM_IDLE;
            end
            default: begin
                r_d.st = EPRGM_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            r_q <= '0;
            r_q.st <= EPRGM_IDLE;
            r_q.pins.chip_sel_n <= 1'b1;
            r_q.pins.out_en_n <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    assign req_ready = (r_q.st == EPRGM_IDLE);
    assign rsp_valid = r_q.done;
    assign rsp = r_q.rsp;
    assign pins = r_q.pins;
endmodule
`default_nettype wire

// >>> bench/eprgm_ctrl_sva.sv
// Checker on the ports of the EPROM programmer controller
`default_nettype none
module eprgm_ctrl_sva import eprgm_pkg::*; #(
    parameter int unsigned MAX_PULSES = 25
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Request side
    input wire logic req_valid,
    input wire logic req_ready,
    input wire eprgm_pkg::eprgm_req_t req,
    input wire logic rsp_valid,
    input wire eprgm_pkg::eprgm_rsp_t rsp,
    // Device pins
    input wire eprgm_pkg::eprgm_pins_t pins,
    input wire logic [eprgm_pkg::DATA_W-1:0] data_pins_in
);
    timeunit 1ns;
    timeprecision 100ps;
    int lo_q;
    int st_q;
    int gp_q;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Select low time, steady inputs, time since last pulse or release
    always_ff @(posedge clock) begin
        lo_q <= pins.chip_sel_n ? 0 : lo_q + 1;
        st_q <= ($changed({pins.addr, pins.dout, pins.dout_en})
            || !pins.vpp_hi || !pins.vcc_prog) ? 1 : st_q + 1;
        gp_q <= ($rose(pins.chip_sel_n) || $fell(pins.dout_en)) ? 1
            : gp_q + 1;
    end
    property p_width; $rose(pins.chip_sel_n) && pins.vpp_hi
        |-> lo_q >= 19000 && lo_q <= 21000; endproperty
    a_width: assert property (p_width) else $error("width");
    property p_setup; $fell(pins.chip_sel_n) && pins.vpp_hi
        |-> st_q >= 400; endproperty
    a_setup: assert property (p_setup) else $error("setup");
    property p_hold; $fell(pins.dout_en) || $fell(pins.out_en_n)
        && pins.vpp_hi |-> gp_q >= 400; endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_prog; !pins.chip_sel_n && pins.vpp_hi
        |-> pins.out_en_n && pins.dout_en && pins.vcc_prog; endproperty
    a_prog: assert property (p_prog) else $error("prog");
    property p_vfy; !pins.out_en_n && pins.vpp_hi
        |-> pins.chip_sel_n && pins.vcc_prog && !pins.dout_en; endproperty
    a_vfy: assert property (p_vfy) else $error("verify");
    property p_read; !pins.out_en_n && !pins.vpp_hi
        |-> !pins.chip_sel_n && !pins.dout_en; endproperty
    a_read: assert property (p_read) else $error("read");
    property p_sig; pins.sig_hv |-> !pins.vpp_hi && !pins.vcc_prog
        && pins.addr[18:1] == '0; endproperty
    a_sig: assert property (p_sig) else $error("ident");
    property p_addr; $changed(pins.addr)
        |-> pins.out_en_n && $past(pins.out_en_n); endproperty
    a_addr: assert property (p_addr) else $error("address");
    property p_limit; rsp_valid |-> rsp.pulses <= MAX_PULSES; endproperty
    a_limit: assert property (p_limit) else $error("pulse limit");
endmodule
bind eprgm_ctrl eprgm_ctrl_sva #(.MAX_PULSES(MAX_PULSES)) u_sva (
    .clock(clock), .rst(rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp),
    .pins(pins), .data_pins_in(data_pins_in));
`default_nettype wire

// >>> bench/eprgm_dev_model.sv
// Behavioural byte EPROM on the far side of the programmer
`default_nettype none
module eprgm_dev_model import eprgm_pkg::*; #(
    parameter logic [7:0] MFR_CODE = 8'h5C, // Arbitrary code
    parameter logic [7:0] DEV_CODE = 8'hC3 // Arbitrary code
) (
    // Device pins
    input wire eprgm_pkg::eprgm_pins_t pins,
    output logic [eprgm_pkg::DATA_W-1:0] data_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] mem [256];
    logic [7:0] drv;
    logic [7:0] junk = 8'h3C;
    initial begin
        data_out = 8'h00;
        foreach (mem[i]) mem[i] = 8'hFF;
    end
    // Released lines show a pattern that changes every cycle
    always #5 junk = ~{junk[6:0], junk[7]};
    always @(posedge pins.chip_sel_n)
        if (pins.vpp_hi && pins.vcc_prog && pins.dout_en)
            mem[pins.addr[7:0]] &= pins.dout;
    always_comb begin
        drv = junk;
        if (pins.sig_hv && !pins.vpp_hi && !pins.chip_sel_n
            && !pins.out_en_n)
            drv = pins.addr[0] ? DEV_CODE : MFR_CODE;
        else if (!pins.out_en_n && (!pins.chip_sel_n || pins.vpp_hi))
            drv = mem[pins.addr[7:0]];
    end
    always @(drv) data_out <= #60 drv;
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// Self-checking bench for the EPROM programmer controller
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import eprgm_pkg::*;
    localparam logic [7:0] MFR_ID = 8'h5C; // Arbitrary code
    localparam logic [7:0] DEV_ID = 8'hC3; // Arbitrary code
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    logic req_ready, rsp_valid;
    logic [7:0] dpin, d;
    eprgm_req_t req = '0;
    eprgm_rsp_t rsp, e;
    eprgm_pins_t pins;
    eprgm_rsp_t exp_q[$];
    int err_total = 0;
    int total_checks = 0;
    always #2.5 clock = ~clock;
    eprgm_ctrl #(.MAX_PULSES(2)) u_eprgm_ctrl (.clock(clock), .rst(rst),
        .req_valid(req_valid), .req_ready(req_ready), .req(req),
        .rsp_valid(rsp_valid), .rsp(rsp), .pins(pins), .data_pins_in(dpin));
    eprgm_dev_model #(.MFR_CODE(MFR_ID), .DEV_CODE(DEV_ID))
        u_eprgm_dev_model (.pins(pins), .data_out(dpin));
    task automatic check(string n, logic [8:0] x, logic [8:0] s);
        total_checks++;
        if (s !== x) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", n, x, s);
        end
    endtask
    task automatic summarize();
        if (err_total == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Holds the request until taken, then notes the expected answer
    task automatic issue(eprgm_op_t op, logic [18:0] a, logic [7:0] dt,
        logic [7:0] ed, logic ef, logic [7:0] ep);
        req_valid <= 1'b1;
        req <= '{op, a, dt};
        do @(posedge clock); while (req_ready !== 1'b1);
        exp_q.push_back('{ed, ef, ep});
    endtask
    always @(posedge clock) begin
        if (!rst && rsp_valid === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            check("rsp", {e.data, e.fail}, {rsp.data, rsp.fail});
            if (e.pulses != 8'h00)
                check("pulses", {1'b0, e.pulses}, {1'b0, rsp.pulses});
        end else if (!rst && rsp_valid === 1'b1) begin
            check("extra rsp", 9'h000, 9'h001);
        end
    end
    initial begin
        d = 8'($urandom(59)) & 8'hFE;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        issue(EPRGM_OP_READ, 19'h00077, 8'h00, 8'hFF, 1'b0, 8'h00);
        issue(EPRGM_OP_PROG, 19'h40005, d, d, 1'b0, 8'h01);
        issue(EPRGM_OP_PROG, 19'h40005, ~d, 8'h00, 1'b1, 8'h02);
        issue(EPRGM_OP_READ, 19'h40005, 8'hFF, 8'h00, 1'b0, 8'h00);
        for (int i = 0; i < 2; i++)
            issue(EPRGM_OP_SIG, {18'($urandom), i[0]}, 8'h00,
                i ? DEV_ID : MFR_ID, 1'b0, 8'h00);
        issue(eprgm_op_t'(2'h3), 19'h00001, 8'h00, 8'h00, 1'b1,
            8'h00);
        req_valid <= 1'b0;
        for (int k = 0; k < 900 && exp_q.size() > 0; k++)
            @(posedge clock);
        check("pending", 9'h000, 9'(exp_q.size()));
        summarize();
    end
    initial begin
        #450000;
        err_total++;
        summarize();
    end
endmodule
`default_nettype wire
